// file: hw/prst_reset_if.sv
// prst_reset_if: reset-type interface of the embedded processor block.
// assumes the external reset logic drives the three reset inputs on clk.
// assumes rst comes from the power-up detector, held for an edge or more.
// assumes ce stays high except where the whole block must freeze.
`timescale 1ns/1ps
`default_nettype none
module prst_reset_if
  import prst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic core_reset_in,
  input wire logic chip_reset_in,
  input wire logic system_reset_in,
  input wire logic test_port_reset_n,
  input wire logic [1:0] debug_reset_field,
  input wire logic debug_reset_write,
  input wire logic [1:0] watchdog_reset_control,
  input wire logic watchdog_timeout,
  output logic core_reset_request,
  output logic chip_reset_request,
  output logic system_reset_request,
  output logic [1:0] recorded_reset_type,
  output logic coreHalted,
  output logic coreInReset,
  output logic testPortInReset,
  output logic porActive
);
  import prst_pkg::*;

  typedef struct packed {
    prst_phase_t phase;
    logic [3:0] porCnt;
    logic [3:0] holdCnt;
    logic [1:0] mrr;
    logic halted;
    logic coreRst;
    logic tapRst;
    logic por;
  } prst_state_t;
  prst_state_t st, next_st;

  // merged reset inputs, after the power-on force
  logic effCore;
  logic effChip;
  logic effSys;
  logic effTapN;
  logic porOn;
  logic [1:0] seenType;
  // request path, one bit per reset type
  logic [PRST_NUM_REQ-1:0] trig;
  logic [PRST_NUM_REQ-1:0] matchIn;
  logic [PRST_NUM_REQ-1:0] reqOut;
  logic [1:0] reqCode;

  ////////////////////////////////////////////////////////////////////////
  // power-on merge: internal logic forces every reset input active;
  // the merge sits ahead of every consumer, so power-on looks exactly
  // like a system reset held by the fabric
  assign porOn = (st.phase == PRST_POR);
  assign effCore = core_reset_in | porOn;
  assign effChip = chip_reset_in | porOn;
  assign effSys = system_reset_in | porOn;
  assign effTapN = test_port_reset_n & ~porOn;

  // type decode; system or chip without core still names a type but
  // does not reset the core, and the recorded field is kept as it was
  always_comb begin
    if (effSys) begin
      seenType = PRST_TYPE_SYS;
    end else if (effChip) begin
      seenType = PRST_TYPE_CHIP;
    end else if (effCore) begin
      seenType = PRST_TYPE_CORE;
    end else begin
      seenType = PRST_TYPE_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request triggers from debug writes and watchdog time-outs; both
  // share one code mux and the watchdog wins a tie, since its reset is
  // already committed when the time-out fires
  assign reqCode = watchdog_timeout ? watchdog_reset_control
                                    : debug_reset_field;
  // each slot watches its own input, power-on force included
  assign matchIn[PRST_IDX_CORE] = effCore;
  assign matchIn[PRST_IDX_CHIP] = effChip;
  assign matchIn[PRST_IDX_SYS] = effSys;

  for (genvar i = 0; i < PRST_NUM_REQ; i++) begin : gReq
    // slot index is the type code minus one
    // a code of zero names no reset and raises nothing
    assign trig[i] = (debug_reset_write | watchdog_timeout) &
                     (reqCode == 2'(i + 1));
    prst_req_slot uSlot (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .trigger(trig[i]),
      .matchIn(matchIn[i]),
      .request(reqOut[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencing; requests never feed this path directly
  always_comb begin
    next_st = st;
    // test port follows its own low-active pin and the system input only
    next_st.tapRst = ~effTapN | effSys;

    case (st.phase)
      PRST_POR: begin
        next_st.halted = 1'b1;
        next_st.coreRst = 1'b1;
        next_st.mrr = PRST_TYPE_RST;
        // enabled edges only: a frozen clock enable stretches the phase
        // rather than cutting it short
        if (st.porCnt == PRST_POR_LAST) begin
          next_st.phase = PRST_HALT;
          next_st.holdCnt = PRST_HOLD_LAST;
        end else begin
          next_st.porCnt = 4'(st.porCnt + 4'h1);
        end
      end
      PRST_RUN: begin
        // running: both status bits low
        next_st.halted = 1'b0;
        next_st.coreRst = 1'b0;
        // only the input enters reset, never a pending request
        if (effCore) begin
          // stop at once, whatever the instruction stream is doing
          next_st.phase = PRST_HALT;
          next_st.halted = 1'b1;
          next_st.coreRst = 1'b1;
          next_st.holdCnt = 4'h0;
        end
      end
      PRST_HALT: begin
        next_st.halted = 1'b1;
        next_st.coreRst = 1'b1;
        if (effCore) begin
          // count the hold; release does not wait for the count, so a short pulse ends the halt at once
          if (st.holdCnt != PRST_HOLD_LAST) begin
            next_st.holdCnt = 4'(st.holdCnt + 4'h1);
          end
          // record the widest type seen while core is held
          if (seenType > next_st.mrr || st.holdCnt == 4'h0) begin
            next_st.mrr = seenType;
          end
        end else begin
          // core released: execution and reset status drop together
          next_st.phase = PRST_RUN;
          next_st.halted = 1'b0;
          next_st.coreRst = 1'b0;
        end
      end
      default: begin
        // unreachable phase: restart safely from power-on
        next_st.phase = PRST_POR;
      end
    endcase
    // chip or system without core: field kept, core not reset; this also
    // guards the field if the power-on force is ever taken away
    if (!effCore) begin
      next_st.mrr = (st.phase == PRST_POR) ? PRST_TYPE_RST : next_st.mrr;
    end
    // power-on status as its own flop, so the pin has no decode behind it
    next_st.por = (next_st.phase == PRST_POR);
  end

  // registers; rst stands for power-up and restarts the power-on phase
  // ce low holds every field, the power-on count included
  always_ff @(posedge clk) begin
    if (rst) begin
      st.phase <= PRST_POR;
      st.porCnt <= 4'h0;
      st.holdCnt <= 4'h0;
      st.mrr <= PRST_TYPE_RST;
      st.halted <= 1'b1;
      st.coreRst <= 1'b1;
      st.tapRst <= 1'b1;
      st.por <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request outputs from their slots, status from state flops
  assign core_reset_request = reqOut[PRST_IDX_CORE];
  assign chip_reset_request = reqOut[PRST_IDX_CHIP];
  assign system_reset_request = reqOut[PRST_IDX_SYS];

  // status pins, each a plain state flop
  assign recorded_reset_type = st.mrr;
  assign coreHalted = st.halted;
  assign coreInReset = st.coreRst;
  assign testPortInReset = st.tapRst;
  assign porActive = st.por;
endmodule
`default_nettype wire

// file: hw/prst_pkg.sv
// prst_pkg: constants and types for the processor reset-type interface.
// assumes a single processor clock domain, synchronous active-high reset.
package prst_pkg;
  // reset-type encodings held in the recorded field
  localparam logic [1:0] PRST_TYPE_NONE = 2'h0;
  localparam logic [1:0] PRST_TYPE_CORE = 2'h1;
  localparam logic [1:0] PRST_TYPE_CHIP = 2'h2;
  localparam logic [1:0] PRST_TYPE_SYS = 2'h3;
  localparam logic [1:0] PRST_TYPE_RST = 2'h3;
  // least hold of any reset input, in processor clock cycles
  localparam int PRST_MIN_HOLD_CYC = 8;
  localparam logic [3:0] PRST_HOLD_LAST = 4'(PRST_MIN_HOLD_CYC - 1);
  // request stays up this many cycles after the matching input rises
  localparam int PRST_REQ_TAIL_CYC = 2;
  localparam logic [1:0] PRST_TAIL_LAST = 2'(PRST_REQ_TAIL_CYC - 1);
  // power-on phase length, at least the least hold
  localparam logic [3:0] PRST_POR_LAST = 4'(PRST_MIN_HOLD_CYC - 1);
  localparam int PRST_NUM_REQ = 3;
  // request index per type
  localparam int PRST_IDX_CORE = 0;
  localparam int PRST_IDX_CHIP = 1;
  localparam int PRST_IDX_SYS = 2;
  typedef enum {PRST_POR, PRST_RUN, PRST_HALT} prst_phase_t;
endpackage

// file: hw/prst_req_slot.sv
// prst_req_slot: one reset-request output with its release tail.
// assumes the trigger and the matching reset input are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module prst_req_slot
  import prst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic trigger,
  input wire logic matchIn,
  output logic request
);
  typedef struct packed {
    logic req;
    logic tailOn;
    logic [1:0] tail;
  } prst_slot_t;
  prst_slot_t st, next_st;

  // hold until two cycles after the matching input is seen asserted
  always_comb begin
    next_st = st;
    if (st.req && st.tailOn) begin
      if (st.tail == PRST_TAIL_LAST) begin
        next_st.req = 1'b0;
        next_st.tailOn = 1'b0;
      end else begin
        next_st.tail = 2'(st.tail + 2'h1);
      end
    end else if (st.req && matchIn) begin
      next_st.tailOn = 1'b1;
      next_st.tail = 2'h0;
    end
    // a new trigger outside a tail raises the request
    if (trigger && !next_st.req) begin
      next_st.req = 1'b1;
      next_st.tailOn = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign request = st.req;
endmodule
`default_nettype wire

// file: testbench/prst_reset_if_chk.sv
// prst_reset_if_chk: port assertions for the reset-type interface.
// assumes it is bound onto prst_reset_if, one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module prst_reset_if_chk
  import prst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic core_reset_in,
  input wire logic chip_reset_in,
  input wire logic system_reset_in,
  input wire logic test_port_reset_n,
  input wire logic [1:0] debug_reset_field,
  input wire logic debug_reset_write,
  input wire logic [1:0] watchdog_reset_control,
  input wire logic watchdog_timeout,
  input wire logic core_reset_request,
  input wire logic chip_reset_request,
  input wire logic system_reset_request,
  input wire logic [1:0] recorded_reset_type,
  input wire logic coreHalted,
  input wire logic coreInReset,
  input wire logic testPortInReset,
  input wire logic porActive
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  // two more cycles of request, then release
  sequence s_tail;
    core_reset_request ##1 core_reset_request ##1 !core_reset_request;
  endsequence
  // chip type applied, power-on phase over
  sequence s_chip;
    ce && core_reset_in && chip_reset_in && !system_reset_in && !porActive;
  endsequence
  a_req_tail: assert property (
    ce && core_reset_request && core_reset_in && !$past(core_reset_in)
    |=> s_tail) else $error("request tail wrong");
  a_dbg_core: assert property (
    ce && debug_reset_write && !watchdog_timeout &&
    debug_reset_field == 2'h1 |=> core_reset_request)
    else $error("debug request missing");
  a_dbg_chip: assert property (
    ce && debug_reset_write && !watchdog_timeout &&
    debug_reset_field == PRST_TYPE_CHIP |=> chip_reset_request)
    else $error("chip request missing");
  a_wdog_sys: assert property (
    ce && watchdog_timeout && watchdog_reset_control == 2'h3
    |=> system_reset_request) else $error("watchdog request missing");
  a_no_self: assert property (
    ce && core_reset_request && !core_reset_in && !coreInReset &&
    !porActive |=> !coreInReset) else $error("request reset the core");
  a_halt_follow: assert property (
    ce && core_reset_in |=> coreInReset && coreHalted)
    else $error("core not halted");
  a_halt_leave: assert property (
    (ce && !core_reset_in && !porActive) [*2] |=> !coreInReset)
    else $error("core stuck in reset");
  a_rec_chip: assert property (
    s_chip [*2] |=> recorded_reset_type == PRST_TYPE_CHIP)
    else $error("chip type not recorded");
  a_rec_keep: assert property (
    ce && !core_reset_in && !coreInReset && !porActive
    |=> $stable(recorded_reset_type)) else $error("type changed");
  a_test_port: assert property (
    ce && (system_reset_in || !test_port_reset_n) |=> testPortInReset)
    else $error("test port not reset");
  a_por_len: assert property (
    $fell(rst) |-> porActive [*8]) else $error("power-on too short");
endmodule
`default_nettype wire

// file: testbench/prst_far_reset.sv
// prst_far_reset: fabric logic that makes the three reset inputs.
// assumes the processor clock; the bench may command a raw combination.
`timescale 1ns/1ps
`default_nettype none
module prst_far_reset
  import prst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic coreReq,
  input wire logic chipReq,
  input wire logic sysReq,
  input wire logic go,
  input wire logic [2:0] goBits,
  output logic coreIn,
  output logic chipIn,
  output logic sysIn
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] bits = 3'h0;
  // driven from registers only, so always clk-synchronous
  assign {sysIn, chipIn, coreIn} = (cnt != 4'h0) ? bits : 3'h0;
  // widest request wins; held for the least hold, never longer
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (go || coreReq || chipReq || sysReq) begin
      cnt <= 4'(PRST_MIN_HOLD_CYC);
      bits <= go ? goBits : sysReq ? 3'h7 : chipReq ? 3'h3 : 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// testbench: self-checking bench for the reset-type interface.
// assumes the design, far-side model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prst_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] dField = 2'h0;
  logic [1:0] wCtl = 2'h0;
  logic dWr = 1'b0;
  logic wTo = 1'b0;
  logic go = 1'b0;
  logic [2:0] goBits = 3'h0;
  logic coreIn, chipIn, sysIn, coreReq, chipReq, sysReq;
  logic [1:0] recType;
  logic halted, inRst, tpRst, por;
  int fail_count = 0;
  int samples_checked = 0;
  initial forever #2 clk = ~clk;
  // test port held released; power-on drives it internally
  prst_reset_if i_dut (.clk(clk), .rst(rst), .ce(1'b1),
    .core_reset_in(coreIn), .chip_reset_in(chipIn),
    .system_reset_in(sysIn), .test_port_reset_n(1'b1),
    .debug_reset_field(dField), .debug_reset_write(dWr),
    .watchdog_reset_control(wCtl), .watchdog_timeout(wTo),
    .core_reset_request(coreReq), .chip_reset_request(chipReq),
    .system_reset_request(sysReq), .recorded_reset_type(recType),
    .coreHalted(halted), .coreInReset(inRst),
    .testPortInReset(tpRst), .porActive(por));
  prst_far_reset i_far (.clk(clk), .rst(rst), .coreReq(coreReq),
    .chipReq(chipReq), .sysReq(sysReq), .go(go), .goBits(goBits),
    .coreIn(coreIn), .chipIn(chipIn), .sysIn(sysIn));
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // bounded wait on the core reset status
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (inRst !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (inRst !== v) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic t_por();
    // a mid-run reset starts on a rising edge like any other stimulus
    if (rst !== 1'b1) begin
      @(posedge clk);
      rst <= 1'b1;
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({1'b0, por, recType}, 4'h7);
    check({tpRst, sysReq, chipReq, coreReq}, 4'h8);
    wait_lvl(1'b0);
    check({2'h0, recType}, {2'h0, PRST_TYPE_RST});
    $display("t_por done");
  endtask
  // code 0 must raise nothing; watchdog code beats the debug code
  task automatic t_request(input logic [1:0] c, input logic w);
    logic [3:0] expReq;
    expReq = 4'h0;
    if (c != 2'h0) begin
      expReq = 4'h1 << (c - 2'h1);
    end
    @(posedge clk);
    dField <= w ? ~c : c;
    wCtl <= c;
    dWr <= 1'b1;
    wTo <= w;
    @(posedge clk);
    dWr <= 1'b0;
    wTo <= 1'b0;
    repeat (2) @(negedge clk);
    check({inRst, sysReq, chipReq, coreReq}, expReq);
    if (c != 2'h0) begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      check({halted, 1'b0, recType}, {2'h0, c});
      check({1'b0, sysReq, chipReq, coreReq}, 4'h0);
    end
    $display("t_request done");
  endtask
  // combination without core: no core reset, type kept
  task automatic t_illegal(input logic [2:0] b);
    @(posedge clk);
    go <= 1'b1;
    goBits <= b;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(negedge clk);
    check({2'h0, tpRst, inRst}, {2'h0, b[2], 1'b0});
    repeat (8) @(negedge clk);
    check({2'h0, recType}, {2'h0, PRST_TYPE_CORE});
    $display("t_illegal done");
  endtask
  initial begin
    t_por();
    for (int w = 0; w < 2; w++) begin
      for (int c = 0; c < 4; c++) begin
        t_request(2'(c), 1'(w));
      end
    end
    // a core reset first, so a kept field is told apart from 2 or 3
    t_request(2'h1, 1'b0);
    t_illegal(3'h2);
    t_illegal(3'h4);
    t_por();
    finish_test();
  end
endmodule
bind prst_reset_if prst_reset_if_chk i_chk (
  .clk(clk), .rst(rst), .ce(ce), .core_reset_in(core_reset_in),
  .chip_reset_in(chip_reset_in), .system_reset_in(system_reset_in),
  .test_port_reset_n(test_port_reset_n),
  .debug_reset_field(debug_reset_field),
  .debug_reset_write(debug_reset_write),
  .watchdog_reset_control(watchdog_reset_control),
  .watchdog_timeout(watchdog_timeout),
  .core_reset_request(core_reset_request),
  .chip_reset_request(chip_reset_request),
  .system_reset_request(system_reset_request),
  .recorded_reset_type(recorded_reset_type),
  .coreHalted(coreHalted), .coreInReset(coreInReset),
  .testPortInReset(testPortInReset), .porActive(porActive));
`default_nettype wire
